//--- src/wdtc_consts.svh
// Register offsets, field positions, reset values and counts for the watchdog timer.
`ifndef WDTC_CONSTS_SVH
`define WDTC_CONSTS_SVH

// Register bus geometry and the single control and status register.
`define WDTC_ADDR_W        4
`define WDTC_CTRL_OFS      4'h0
`define WDTC_RDATA_IDLE    8'h00

// Field positions in the control and status register.
`define WDTC_BIT_FLAG      7
`define WDTC_BIT_IRQ_EN    6
`define WDTC_BIT_SEL3      5
`define WDTC_BIT_CHG_EN    4
`define WDTC_BIT_RST_EN    3
`define WDTC_BIT_SEL_HI    2
`define WDTC_BIT_SEL_LO    0

// Reset values of the stored fields.
`define WDTC_RST_FLAG      1'h0
`define WDTC_RST_IRQ_EN    1'h0
`define WDTC_RST_RST_EN    1'h0
`define WDTC_RST_SEL       4'h0

// Change window length in system clock cycles.
`define WDTC_CHG_CYCLES    3'h4
`define WDTC_CHG_IDLE      3'h0

// Oscillator period table: shortest period and the last defined code.
`define WDTC_CNT_W         21
`define WDTC_PERIOD_MIN    21'h000800
`define WDTC_SEL_MAX       4'h9
`define WDTC_CNT_ZERO      21'h000000
`define WDTC_CNT_ONE       21'h000001

`endif

//--- src/wdtc_pkg.sv
// Shared types of the watchdog timer.
package wdtc_pkg;

    // Operating mode, as decoded from the fuse and the two enable bits.
    typedef enum logic [1:0] {
        WDTC_STOPPED,
        WDTC_IRQ_ONLY,
        WDTC_RESET_ONLY,
        WDTC_IRQ_THEN_RESET
    } wdtc_mode_e;

endpackage

//--- src/wdtc_counter.sv
// Oscillator cycle counter with selectable time-out period.
`include "wdtc_consts.svh"

module wdtc_counter #(
    parameter int CNT_W = `WDTC_CNT_W
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Control.
    input  wire logic             run_i,
    input  wire logic             restart_i,
    input  wire logic             tick_i,
    input  wire logic [3:0]       sel_i,
    // Event.
    output logic                  timeout_o
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [3:0]       sel_eff;
    logic [CNT_W-1:0] limit;
    logic             at_end;

    ////////////////////////////////////////////////////////////////////////////
    // Period decode: reserved codes fall back to the longest defined period.
    assign sel_eff = (sel_i > `WDTC_SEL_MAX) ? `WDTC_SEL_MAX : sel_i;
    assign limit   = CNT_W'(`WDTC_PERIOD_MIN) << sel_eff;
    assign at_end  = (cnt_ff == (limit - CNT_W'(`WDTC_CNT_ONE)));

    // A restart wins over a tick, so the count always resumes from zero.
    assign nxt_cnt = (!run_i || restart_i) ? CNT_W'(`WDTC_CNT_ZERO) :
                     !tick_i               ? cnt_ff :
                     at_end                ? CNT_W'(`WDTC_CNT_ZERO) :
                                             cnt_ff + CNT_W'(`WDTC_CNT_ONE);

    ////////////////////////////////////////////////////////////////////////////
    // Count register.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_ff <= CNT_W'(`WDTC_CNT_ZERO);
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Time-out is combinational so the control logic reacts in the same cycle.
    assign timeout_o = run_i && !restart_i && tick_i && at_end;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_restart_zero: assert property (restart_i |=> cnt_ff == '0)
        else $error("Counter not cleared by restart.");
    a_period_exact: assert property (timeout_o |->
        cnt_ff == (CNT_W'(`WDTC_PERIOD_MIN) << sel_eff) - CNT_W'(`WDTC_CNT_ONE))
        else $error("Time-out at wrong count.");
    a_reserved_max: assert property ((sel_i > `WDTC_SEL_MAX) |->
        limit == (CNT_W'(`WDTC_PERIOD_MIN) << `WDTC_SEL_MAX))
        else $error("Reserved code does not give longest period.");
    a_tick_counts: assert property (run_i && tick_i && !restart_i && !at_end
        |=> cnt_ff == $past(cnt_ff) + CNT_W'(`WDTC_CNT_ONE))
        else $error("Oscillator tick not counted.");

endmodule

//--- src/wdtc_top.sv
// Watchdog timer: control and status register, mode decode, time-out actions.
//
// Our own choices: the plain strobed port and the address map.
`include "wdtc_consts.svh"

module wdtc_top #(
    parameter int CNT_W = `WDTC_CNT_W
) (
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    // Register port.
    input  wire logic [`WDTC_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [7:0]              rdata_o,
    // Processor side.
    input  wire logic                    osc_tick_i,
    input  wire logic                    restart_i,
    input  wire logic                    vector_ack_i,
    input  wire logic                    global_irq_en_i,
    // Fuse and reset status.
    input  wire logic                    always_on_fuse_i,
    input  wire logic                    reset_cause_flag_i,
    // Outputs to the system.
    output logic                         irq_req_o,
    output logic                         sys_reset_o
);

    // Stored register state.
    logic                    flag_ff;
    logic                    irq_en_ff;
    logic                    rst_en_ff;
    logic [3:0]              sel_ff;
    logic [2:0]              chg_cnt_ff;
    logic                    irq_ff;
    logic                    sys_reset_ff;
    logic [7:0]              rdata_ff;

    // Next values.
    logic                    nxt_flag;
    logic                    nxt_irq_en;
    logic                    nxt_rst_en;
    logic [3:0]              nxt_sel;
    logic [2:0]              nxt_chg_cnt;
    logic [7:0]              nxt_rdata;

    // Decoded terms.
    logic                    wr_hit;
    logic                    rd_hit;
    logic                    rst_en_eff;
    logic                    irq_en_eff;
    logic                    chg_open;
    logic                    chg_start;
    logic                    rst_en_clear_ok;
    logic                    wr_flag_one;
    logic                    timeout;
    logic                    to_irq;
    logic                    to_reset;
    logic                    vec_clear_en;
    logic                    run;
    logic [7:0]              reg_view;
    wdtc_pkg::wdtc_mode_e    mode;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode. Only one register exists; other addresses read zero.
    assign wr_hit = wr_i && (addr_i == `WDTC_CTRL_OFS);
    assign rd_hit = rd_i && (addr_i == `WDTC_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Effective enables. The fuse and the reset-cause flag override the stored
    // bits without changing them, so the stored value returns once they drop.
    assign rst_en_eff = rst_en_ff || always_on_fuse_i || reset_cause_flag_i;
    assign irq_en_eff = irq_en_ff && !always_on_fuse_i;

    // Mode decode from the fuse and the two effective enables.
    always_comb begin
        case ({always_on_fuse_i, rst_en_eff, irq_en_eff})
            3'h0:    mode = wdtc_pkg::WDTC_STOPPED;
            3'h1:    mode = wdtc_pkg::WDTC_IRQ_ONLY;
            3'h2:    mode = wdtc_pkg::WDTC_RESET_ONLY;
            3'h3:    mode = wdtc_pkg::WDTC_IRQ_THEN_RESET;
            default: mode = wdtc_pkg::WDTC_RESET_ONLY;
        endcase
    end

    assign run = (mode != wdtc_pkg::WDTC_STOPPED);

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator cycle counter.
    wdtc_counter #(
        .CNT_W     (CNT_W)
    ) u_counter (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (run),
        .restart_i (restart_i),
        .tick_i    (osc_tick_i),
        .sel_i     (sel_ff),
        .timeout_o (timeout)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Time-out actions. In the combined mode the first time-out only raises
    // the flag; a second one while the flag is still pending resets.
    assign to_irq   = timeout && ((mode == wdtc_pkg::WDTC_IRQ_ONLY) ||
                      ((mode == wdtc_pkg::WDTC_IRQ_THEN_RESET) && !flag_ff));
    assign to_reset = timeout && ((mode == wdtc_pkg::WDTC_RESET_ONLY) ||
                      ((mode == wdtc_pkg::WDTC_IRQ_THEN_RESET) && flag_ff));

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt flag: set wins over both clear sources.
    assign wr_flag_one = wr_hit && wdata_i[`WDTC_BIT_FLAG];
    assign nxt_flag    = to_irq ||
                         (flag_ff && !vector_ack_i && !wr_flag_one);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt enable: software write wins; vector in combined mode clears it.
    assign vec_clear_en = vector_ack_i && (mode == wdtc_pkg::WDTC_IRQ_THEN_RESET);
    assign nxt_irq_en   = wr_hit       ? wdata_i[`WDTC_BIT_IRQ_EN] :
                          vec_clear_en ? 1'b0 :
                                         irq_en_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Change window. Opening it needs change enable and reset enable in one
    // write; it then stays open for a fixed number of system clock cycles.
    assign chg_start   = wr_hit && wdata_i[`WDTC_BIT_CHG_EN] && wdata_i[`WDTC_BIT_RST_EN];
    assign chg_open    = (chg_cnt_ff != `WDTC_CHG_IDLE);
    assign nxt_chg_cnt = chg_start ? `WDTC_CHG_CYCLES :
                         chg_open  ? chg_cnt_ff - 3'h1 :
                                     `WDTC_CHG_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Protected fields. Setting reset enable is always allowed; clearing it
    // and changing the period need the window, and a pending reset-cause
    // flag blocks the clear so repeated failures keep resetting.
    assign rst_en_clear_ok = chg_open && !reset_cause_flag_i;
    assign nxt_rst_en = wr_hit ? (wdata_i[`WDTC_BIT_RST_EN] ||
                                  (rst_en_ff && !rst_en_clear_ok)) : rst_en_ff;
    assign nxt_sel    = (wr_hit && chg_open) ?
                        {wdata_i[`WDTC_BIT_SEL3],
                         wdata_i[`WDTC_BIT_SEL_HI:`WDTC_BIT_SEL_LO]} : sel_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Read view and read data, valid only in the cycle after the strobe.
    assign reg_view  = {flag_ff, irq_en_eff, sel_ff[3], chg_open,
                        rst_en_eff, sel_ff[2:0]};
    assign nxt_rdata = rd_hit ? reg_view : `WDTC_RDATA_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Control and status registers.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            flag_ff    <= `WDTC_RST_FLAG;
            irq_en_ff  <= `WDTC_RST_IRQ_EN;
            rst_en_ff  <= `WDTC_RST_RST_EN;
            sel_ff     <= `WDTC_RST_SEL;
            chg_cnt_ff <= `WDTC_CHG_IDLE;
        end else begin
            flag_ff    <= nxt_flag;
            irq_en_ff  <= nxt_irq_en;
            rst_en_ff  <= nxt_rst_en;
            sel_ff     <= nxt_sel;
            chg_cnt_ff <= nxt_chg_cnt;
        end
    end

    // Output registers. The request is gated by the global enable here, so
    // software masking takes effect one cycle later.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_ff       <= 1'b0;
            sys_reset_ff <= 1'b0;
            rdata_ff     <= `WDTC_RDATA_IDLE;
        end else begin
            irq_ff       <= flag_ff && irq_en_eff && global_irq_en_i;
            sys_reset_ff <= to_reset;
            rdata_ff     <= nxt_rdata;
        end
    end

    assign irq_req_o   = irq_ff;
    assign sys_reset_o = sys_reset_ff;
    assign rdata_o     = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_flag_on_timeout: assert property (
        timeout && (mode == wdtc_pkg::WDTC_IRQ_ONLY) |=> flag_ff)
        else $error("Flag not set on interrupt-mode time-out.");

    a_vector_clears: assert property (
        vector_ack_i && !to_irq |=> !flag_ff)
        else $error("Vector did not clear the flag.");

    a_write_one_clr: assert property (
        wr_hit && wdata_i[`WDTC_BIT_FLAG] && !to_irq |=> !flag_ff)
        else $error("Write of one did not clear the flag.");

    a_write_zero_keep: assert property (
        wr_hit && !wdata_i[`WDTC_BIT_FLAG] && flag_ff && !vector_ack_i |=> flag_ff)
        else $error("Write of zero changed the flag.");

    a_irq_gating: assert property (
        irq_req_o == $past(flag_ff && irq_en_eff && global_irq_en_i))
        else $error("Interrupt request not gated by flag and enables.");

    a_fuse_mode: assert property (
        always_on_fuse_i |-> (mode == wdtc_pkg::WDTC_RESET_ONLY) && reg_view[6:6] == 1'b0)
        else $error("Fuse does not force reset-only mode.");

    a_fuse_lock: assert property (
        always_on_fuse_i && wr_hit |=> rst_en_eff && !irq_en_eff)
        else $error("Fuse lock broken by a write.");

    a_vector_to_reset: assert property (
        vec_clear_en && !wr_hit && !to_irq |=> !irq_en_ff && !flag_ff)
        else $error("Combined mode did not fall back to reset-only.");

    a_second_timeout: assert property (
        timeout && (mode == wdtc_pkg::WDTC_IRQ_THEN_RESET) && flag_ff |=> sys_reset_o)
        else $error("Pending flag at time-out did not reset.");

    a_sel_locked: assert property (
        wr_hit && !chg_open |=> sel_ff == $past(sel_ff))
        else $error("Period changed outside the change window.");

    a_window_close: assert property (
        chg_start ##1 (!chg_start)[*4] |=> !chg_open)
        else $error("Change window not closed after four cycles.");

    a_window_open: assert property (
        chg_start |=> chg_open[*4])
        else $error("Change window shorter than four cycles.");

    a_cause_holds_en: assert property (
        reset_cause_flag_i && wr_hit |=> rst_en_ff == $past(rst_en_ff) || rst_en_ff)
        else $error("Reset enable cleared while reset cause pending.");

    a_read_layout: assert property (
        rd_hit |=> rdata_o == {$past(flag_ff), $past(irq_en_eff), $past(sel_ff[3]),
                               $past(chg_open), $past(rst_en_eff), $past(sel_ff[2:0])})
        else $error("Read data does not follow register layout.");

    // Outputs and protected fields as the system sees them. The output checks and a_cause_forces
    // look past the stored bits, so a slip in the effective-enable terms shows up there;
    // a_vector_keeps_en, a_window_sel and a_rst_set_free check the stored bits.
    a_rdata_idle: assert property (
        !rd_hit |=> rdata_o == `WDTC_RDATA_IDLE)
        else $error("Read data not idle outside a read.");

    a_reset_mode_pulse: assert property (
        timeout && (mode == wdtc_pkg::WDTC_RESET_ONLY) |=> sys_reset_o)
        else $error("Reset-only time-out did not reset.");

    a_irq_mode_quiet: assert property (
        timeout && (mode == wdtc_pkg::WDTC_IRQ_ONLY) |=> !sys_reset_o)
        else $error("Interrupt-only time-out caused a reset.");

    a_stopped_quiet: assert property (
        (mode == wdtc_pkg::WDTC_STOPPED) |=> !sys_reset_o)
        else $error("Stopped watchdog caused a reset.");

    a_vector_keeps_en: assert property (
        vector_ack_i && !wr_hit && (mode == wdtc_pkg::WDTC_IRQ_ONLY) |=> irq_en_ff)
        else $error("Vector cleared the enable in interrupt-only mode.");

    a_window_sel: assert property (
        wr_hit && chg_open |=> sel_ff == $past({wdata_i[`WDTC_BIT_SEL3],
            wdata_i[`WDTC_BIT_SEL_HI:`WDTC_BIT_SEL_LO]}))
        else $error("Period not taken inside the change window.");

    a_rst_set_free: assert property (
        wr_hit && wdata_i[`WDTC_BIT_RST_EN] |=> rst_en_ff)
        else $error("Reset enable not set by a write of one.");

    a_cause_forces: assert property (
        reset_cause_flag_i |-> reg_view[`WDTC_BIT_RST_EN] && run)
        else $error("Reset cause does not force reset enable.");

    c_irq_timeout:  cover property (timeout && (mode == wdtc_pkg::WDTC_IRQ_ONLY));
    c_reset_out:    cover property (sys_reset_o);
    c_window_clear: cover property (chg_start ##[1:4] (wr_hit && !wdata_i[`WDTC_BIT_RST_EN]));
    c_combined_vec: cover property (vec_clear_en ##1 (mode == wdtc_pkg::WDTC_RESET_ONLY));
    c_cause_reset:  cover property (reset_cause_flag_i && timeout);

endmodule

//--- verif/test_watchdog_timer_ctrl.sv
// Self-checking testbench for the watchdog timer and its control and status register.
module test_watchdog_timer_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk_i, resetn_i, wr_i, rd_i, osc_tick_i, restart_i, vector_ack_i;
    logic       global_irq_en_i, always_on_fuse_i, reset_cause_flag_i;
    logic       irq_req_o, sys_reset_o, irq_s, rst_s, irq_e, rst_e;
    logic [3:0] addr_i, a;
    logic [7:0] wdata_i, rdata_o, d;
    int         miscompares, n_tests, n_rst, n, r0;
    integer     seed;

    wdtc_top i_wdtc_top (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .osc_tick_i(osc_tick_i), .restart_i(restart_i), .vector_ack_i(vector_ack_i),
        .global_irq_en_i(global_irq_en_i), .always_on_fuse_i(always_on_fuse_i),
        .reset_cause_flag_i(reset_cause_flag_i), .irq_req_o(irq_req_o),
        .sys_reset_o(sys_reset_o));

    // Clock of 5 ns period.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Outputs are sampled mid-cycle so the driver never races the design's own edge.
    always @(negedge clk_i) begin
        irq_s <= irq_req_o;
        rst_s <= sys_reset_o;
        if (sys_reset_o === 1'b1) n_rst <= n_rst + 1;
    end

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi, input string what);
        n_tests++;
        if (v < lo || v > hi) begin
            miscompares++;
            $display("unexpected at %0t: %s took %0d ticks", $time, what, v);
        end
    endtask

    // One bus cycle; every call lasts exactly one clock so strobes are never doubled.
    task automatic bus(input logic w, input logic r, input logic [3:0] ad, input logic [7:0] v);
        wr_i <= w;
        rd_i <= r;
        addr_i <= ad;
        wdata_i <= v;
        @(posedge clk_i);
    endtask

    task automatic idle(input int k);
        repeat (k) bus(1'b0, 1'b0, 4'h0, 8'h00);
    endtask

    // Read data stand only in the cycle after the strobe, so they are looked at there.
    task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
        bus(1'b0, 1'b1, ad, 8'h00);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp, "read data");
        @(posedge clk_i);
    endtask

    // Opens the change window, then writes the protected value in the next cycle.
    task automatic prot(input logic [7:0] v);
        bus(1'b1, 1'b0, 4'h0, 8'h18);
        bus(1'b1, 1'b0, 4'h0, v);
        idle(5);
    endtask

    task automatic pulse_restart;
        restart_i <= 1'b1;
        idle(1);
        restart_i <= 1'b0;
        idle(1);
    endtask

    // Runs the oscillator at full rate until the chosen output shows or the bound runs out.
    task automatic run(input logic want_rst, input int limit);
        osc_tick_i <= 1'b1;
        n = 0;
        do begin
            idle(1);
            n++;
        end while ((want_rst ? rst_s : irq_s) !== 1'b1 && n < limit);
        osc_tick_i <= 1'b0;
    endtask

    // Waits for a time-out of the given period; a hang ends the run.
    task automatic expect_to(input logic want_rst, input int per);
        run(want_rst, per + 6);
        if (n > per + 5) begin
            miscompares++;
            $display("unexpected at %0t: no time-out seen", $time);
            give_verdict();
        end
        chk_rng(n, per, per + 5, "time-out period");
    endtask

    function automatic logic [7:0] exp_csr(input logic ie, input logic re);
        return {1'b0, ie, 2'b00, re, 3'h0};
    endfunction

    initial begin
        {wr_i, rd_i, osc_tick_i, restart_i, vector_ack_i} = 5'h00;
        {always_on_fuse_i, reset_cause_flag_i} = 2'h0;
        global_irq_en_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        resetn_i = 1'b0;
        {miscompares, n_tests, n_rst} = 0;
        seed = 31994;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 8'h00);
        $display("test reset values done");

        // Random writes outside the window: only unprotected bits may move.
        {irq_e, rst_e} = 2'b00;
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[4] = 1'b0;
            a = 4'($random(seed)) & 4'h3;
            bus(1'b1, 1'b0, a, d);
            if (a == 4'h0) begin
                irq_e = d[6];
                rst_e = rst_e | d[3];
            end
            rd(4'h0, exp_csr(irq_e, rst_e));
            rd(a | 4'h4, 8'h00);
        end
        $display("test random writes done");

        // Window opening, accepted write in the window, last cycle and first closed cycle.
        bus(1'b1, 1'b0, 4'h0, 8'h18);
        rd(4'h0, exp_csr(1'b0, 1'b1) | 8'h10);
        bus(1'b1, 1'b0, 4'h0, 8'h21);
        idle(5);
        rd(4'h0, 8'h21);
        bus(1'b1, 1'b0, 4'h0, 8'h18);
        idle(3);
        bus(1'b1, 1'b0, 4'h0, 8'h00);
        idle(5);
        rd(4'h0, 8'h00);
        bus(1'b1, 1'b0, 4'h0, 8'h18);
        idle(4);
        bus(1'b1, 1'b0, 4'h0, 8'h01);
        idle(5);
        rd(4'h0, 8'h08);
        prot(8'h00);
        $display("test change window done");

        // Stopped mode never times out.
        pulse_restart();
        r0 = n_rst;
        run(1'b0, 3000);
        chk_rng(n, 3000, 3000, "stopped mode");
        chk(8'(n_rst - r0), 8'h00, "reset count");
        rd(4'h0, 8'h00);

        // Interrupt-only mode with flag handling.
        bus(1'b1, 1'b0, 4'h0, 8'h40);
        pulse_restart();
        expect_to(1'b0, 2048);
        rd(4'h0, 8'hc0);
        chk(8'(n_rst - r0), 8'h00, "reset count");
        global_irq_en_i <= 1'b0;
        idle(3);
        chk({7'h00, irq_s}, 8'h00, "request masked");
        global_irq_en_i <= 1'b1;
        idle(3);
        chk({7'h00, irq_s}, 8'h01, "request restored");
        bus(1'b1, 1'b0, 4'h0, 8'h40);
        rd(4'h0, 8'hc0);
        bus(1'b1, 1'b0, 4'h0, 8'hc0);
        idle(2);
        chk({7'h00, irq_s}, 8'h00, "request after clear");
        rd(4'h0, 8'h40);
        pulse_restart();
        expect_to(1'b0, 2048);
        vector_ack_i <= 1'b1;
        idle(1);
        vector_ack_i <= 1'b0;
        idle(2);
        rd(4'h0, 8'h40);
        $display("test interrupt mode done");

        // A restart in mid-count keeps the time-out away.
        pulse_restart();
        run(1'b1, 2000);
        pulse_restart();
        run(1'b0, 2000);
        chk_rng(n, 2000, 2000, "restart");
        prot(8'hc1);
        pulse_restart();
        expect_to(1'b0, 4096);
        $display("test restart and period done");

        // Interrupt then reset: serviced once, then left without service.
        prot(8'hc8);
        pulse_restart();
        r0 = n_rst;
        expect_to(1'b0, 2048);
        chk(8'(n_rst - r0), 8'h00, "reset count");
        vector_ack_i <= 1'b1;
        idle(1);
        vector_ack_i <= 1'b0;
        idle(1);
        rd(4'h0, 8'h08);
        pulse_restart();
        expect_to(1'b1, 2048);
        idle(3);
        chk(8'(n_rst - r0), 8'h01, "single reset pulse");
        bus(1'b1, 1'b0, 4'h0, 8'h48);
        pulse_restart();
        expect_to(1'b0, 2048);
        r0 = n_rst;
        pulse_restart();
        expect_to(1'b1, 2048);
        idle(3);
        chk(8'(n_rst - r0), 8'h01, "unserviced reset");
        $display("test interrupt then reset done");

        // Reset-cause flag holds reset enable.
        bus(1'b1, 1'b0, 4'h0, 8'h80);
        prot(8'h00);
        reset_cause_flag_i <= 1'b1;
        prot(8'h00);
        rd(4'h0, 8'h08);
        pulse_restart();
        expect_to(1'b1, 2048);
        reset_cause_flag_i <= 1'b0;
        rd(4'h0, 8'h08);
        prot(8'h00);
        rd(4'h0, 8'h00);

        // Fuse forces reset mode and locks the enables.
        always_on_fuse_i <= 1'b1;
        bus(1'b1, 1'b0, 4'h0, 8'h40);
        rd(4'h0, 8'h08);
        pulse_restart();
        expect_to(1'b1, 2048);
        chk({7'h00, irq_s}, 8'h00, "no request under fuse");
        always_on_fuse_i <= 1'b0;
        prot(8'h00);
        $display("test cause flag and fuse done");

        // A reserved code must not give a short period.
        prot(8'h62);
        rd(4'h0, 8'h62);
        pulse_restart();
        run(1'b0, 20000);
        chk_rng(n, 20000, 20000, "reserved code");
        $display("test reserved code done");
        give_verdict();
    end
endmodule
